// File: hdl/enc_zero_dir.sv
// Zero/preset and counting-direction control of an absolute rotary encoder
module enc_zero_dir (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // External pins
    input wire logic zero_in,
    input wire logic dir_in,
    // Configuration and sensing
    input wire enc_ctl_pkg::cfg_t cfg,
    input wire enc_ctl_pkg::sense_t sense,
    // Results
    output logic [enc_ctl_pkg::POS_W-1:0] position,
    output logic dir_ccw,
    output logic error,
    output logic load_done
);
    // ************************************************************
    // State
    // ************************************************************
    enc_ctl_pkg::state_t s_r;
    enc_ctl_pkg::state_t s_nxt;
    logic release_ok;
    logic hw_allowed;
    logic do_load;
    logic count_up;
    logic err_pending_r;

    always_comb begin
        s_nxt = s_r;
        s_nxt.zero_s1 = zero_in;
        s_nxt.zero_s2 = s_r.zero_s1;
        s_nxt.dir_s1 = dir_in;
        s_nxt.dir_s2 = s_r.dir_s1;
        s_nxt.loaded = 1'b0;
        release_ok = 1'b0;
        // Counter stops at ZERO_MIN_CNT - 1 and the state holds in ZS_ARMED, so very long pulses still qualify
        case (s_r.zst)
            enc_ctl_pkg::ZS_IDLE: begin
                s_nxt.cnt = enc_ctl_pkg::CNT_ZERO;
                if (s_r.zero_s2) begin
                    s_nxt.zst = enc_ctl_pkg::ZS_HIGH;
                    s_nxt.cnt = 11'h001;
                end
            end
            enc_ctl_pkg::ZS_HIGH: begin
                if (!s_r.zero_s2) begin
                    s_nxt.zst = enc_ctl_pkg::ZS_IDLE;
                end else if (s_r.cnt >= enc_ctl_pkg::ZERO_MIN_CNT - 11'h001) begin
                    s_nxt.zst = enc_ctl_pkg::ZS_ARMED;
                end else begin
                    s_nxt.cnt = s_r.cnt + 11'h001;
                end
            end
            enc_ctl_pkg::ZS_ARMED: begin
                if (!s_r.zero_s2) begin
                    s_nxt.zst = enc_ctl_pkg::ZS_IDLE;
                    release_ok = 1'b1;
                end
            end
            default: begin
                s_nxt.zst = enc_ctl_pkg::ZS_IDLE;
            end
        endcase
        // Hardware input gated by enable field only on BiSS
        hw_allowed = !cfg.variant_biss
            || (cfg.preset_hw_en == enc_ctl_pkg::PRESET_HW_ON);
        do_load = (release_ok && hw_allowed)
            || (cfg.variant_biss && cfg.preset_cmd);
        // Direction low means clockwise counts up
        count_up = (sense.step_cw ^ s_r.dir_s2);
        if (do_load) begin
            s_nxt.pos = cfg.variant_biss ? cfg.preset_val
                : enc_ctl_pkg::POS_ZERO;
            s_nxt.loaded = 1'b1;
        end else if (sense.step) begin
            s_nxt.pos = count_up ? s_r.pos + 39'h00_0000_0001
                : s_r.pos - 39'h00_0000_0001;
        end
        // Backup loss flag is latched by the power domain; the count holds
        // while battery is fine, so a short swap keeps the position
        if (sense.batt_lost_flag) begin
            s_nxt.err = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_r.zero_s1 <= 1'b0;
            s_r.zero_s2 <= 1'b0;
            s_r.dir_s1 <= 1'b0;
            s_r.dir_s2 <= 1'b0;
            s_r.zst <= enc_ctl_pkg::ZS_IDLE;
            s_r.cnt <= enc_ctl_pkg::CNT_ZERO;
            s_r.err <= 1'b0;
            s_r.loaded <= 1'b0;
            // Position is retained across reset while backup holds it;
            // after an uncovered loss only the singleturn part survives
            if (err_pending_r) begin
                s_r.pos <= {enc_ctl_pkg::MT_ZERO, s_r.pos[enc_ctl_pkg::ST_W-1:0]};
            end else begin
                s_r.pos <= s_r.pos;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // Multiturn part is dropped after an uncovered backup loss
    always_ff @(posedge clock) begin
        if (!rstn) begin
            err_pending_r <= 1'b0;
        end else if (sense.batt_lost_flag) begin
            err_pending_r <= 1'b1;
        end
    end

    assign position = s_r.pos;
    assign dir_ccw = s_r.dir_s2;
    assign error = s_r.err;
    assign load_done = s_r.loaded;

    // ************************************************************
    // Checks
    // ************************************************************
    // ************************************************************
    // Assertion helpers
    // ************************************************************
    // Run length of the synchronised zero level, saturating so long holds stay legal
    logic [enc_ctl_pkg::CNT_W-1:0] hi_run_r;
    always_ff @(posedge clock) begin
        if (!rstn || !s_r.zero_s2) begin
            hi_run_r <= enc_ctl_pkg::CNT_ZERO;
        end else if (!(&hi_run_r)) begin
            hi_run_r <= hi_run_r + 11'h001;
        end
    end

    sequence held_hi;
        s_r.zero_s2 [*8];
    endsequence

    sequence serial_release;
        s_r.zst == enc_ctl_pkg::ZS_ARMED && !s_r.zero_s2 && !cfg.variant_biss;
    endsequence

    sequence biss_release;
        s_r.zst == enc_ctl_pkg::ZS_ARMED && !s_r.zero_s2 && cfg.variant_biss
            && cfg.preset_hw_en == enc_ctl_pkg::PRESET_HW_ON;
    endsequence

    AST_SHORT_NO_LOAD: assert property (@(posedge clock) disable iff (!rstn)
        (s_r.zst == enc_ctl_pkg::ZS_IDLE) && s_r.zero_s2 ##1 !s_r.zero_s2
        |=> !load_done || (cfg.variant_biss && $past(cfg.preset_cmd)))
        else $error("short pulse loaded position");
    AST_LOAD_ON_RELEASE: assert property (@(posedge clock) disable iff (!rstn)
        serial_release
        |=> load_done && position == enc_ctl_pkg::POS_ZERO)
        else $error("armed release did not zero position");
    AST_ARM_AFTER_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        $rose(s_r.zst == enc_ctl_pkg::ZS_ARMED) |-> hi_run_r >= enc_ctl_pkg::ZERO_MIN_CNT)
        else $error("armed without sustained high");
    // A hardware load needs the level low one cycle earlier, so none ends a hold
    AST_NO_LOAD_WHILE_HELD: assert property (@(posedge clock) disable iff (!rstn)
        held_hi |-> !load_done || $past(cfg.variant_biss && cfg.preset_cmd))
        else $error("position loaded while input held high");
    AST_BISS_HW_LOAD: assert property (@(posedge clock) disable iff (!rstn)
        biss_release |=> load_done && position == $past(cfg.preset_val))
        else $error("enabled hardware preset not loaded");
    AST_BISS_GATE: assert property (@(posedge clock) disable iff (!rstn)
        cfg.variant_biss && cfg.preset_hw_en != enc_ctl_pkg::PRESET_HW_ON
        && !cfg.preset_cmd |=> !load_done)
        else $error("hardware preset honoured while disabled");
    AST_SW_PRESET: assert property (@(posedge clock) disable iff (!rstn)
        cfg.variant_biss && cfg.preset_cmd |=> load_done
        && position == $past(cfg.preset_val))
        else $error("software preset not loaded");
    AST_DIR_UP: assert property (@(posedge clock) disable iff (!rstn)
        sense.step && !do_load && (sense.step_cw ^ s_r.dir_s2)
        |=> position == $past(position) + 39'h00_0000_0001)
        else $error("count direction wrong");
    AST_DIR_DOWN: assert property (@(posedge clock) disable iff (!rstn)
        sense.step && !do_load && !(sense.step_cw ^ s_r.dir_s2)
        |=> position == $past(position) - 39'h00_0000_0001)
        else $error("count direction wrong");
    AST_ERR_RAISE: assert property (@(posedge clock) disable iff (!rstn)
        sense.batt_lost_flag |=> error)
        else $error("backup loss not flagged");
    AST_POS_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        !sense.step && !do_load |=> $stable(position))
        else $error("position drifted at rest");
    AST_DIR_SYNC: assert property (@(posedge clock) disable iff (!rstn)
        $past(rstn) && $past(rstn, 2) |-> dir_ccw == $past(dir_in, 2))
        else $error("direction level not synchronised");

    AST_ERR_STICKY: assert property (@(posedge clock) disable iff (!rstn)
        error |=> error)
        else $error("error indication dropped without power cycle");
    AST_ERR_ONLY_ON_LOSS: assert property (@(posedge clock) disable iff (!rstn)
        !error && !sense.batt_lost_flag |=> !error)
        else $error("error raised without backup loss");

    // ************************************************************
    // Power-cycle checks
    // ************************************************************
    // No disable here: these guard what the reset branch itself does
    AST_RESET_CLEARS_ERR: assert property (@(posedge clock)
        !rstn |=> !error)
        else $error("error indication survived power cycle");
    AST_MT_DROP: assert property (@(posedge clock)
        !rstn && err_pending_r
        |=> position[enc_ctl_pkg::POS_W-1:enc_ctl_pkg::ST_W] == enc_ctl_pkg::MT_ZERO)
        else $error("multiturn count kept after backup loss");
endmodule // enc_zero_dir

// File: pkg/enc_ctl_pkg.sv
// Package of constants and carrier types for the encoder zero/preset and direction logic
package enc_ctl_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int ZERO_MIN_US = 100;
    localparam int ZERO_MIN_CYC = (ZERO_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BATT_SWAP_S = 60;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] ZERO_MIN_CNT = CNT_W'(ZERO_MIN_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

    // ************************************************************
    // Widths and codes
    // ************************************************************
    localparam int ST_W = 23;
    localparam int MT_W = 16;
    localparam int POS_W = ST_W + MT_W;
    localparam logic [1:0] PRESET_HW_ON = 2'h1;
    localparam logic [POS_W-1:0] POS_ZERO = 39'h00_0000_0000;
    localparam logic [MT_W-1:0] MT_ZERO = 16'h0000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [2:0] {
        ZS_IDLE = 3'h1,
        ZS_HIGH = 3'h2,
        ZS_ARMED = 3'h4
    } zero_state_t;

    typedef struct packed {
        logic variant_biss;
        logic [1:0] preset_hw_en;
        logic preset_cmd;
        logic [POS_W-1:0] preset_val;
    } cfg_t;

    typedef struct packed {
        logic step;
        logic step_cw;
        logic batt_ok;
        logic batt_lost_flag;
    } sense_t;

    typedef struct packed {
        logic zero_s1;
        logic zero_s2;
        logic dir_s1;
        logic dir_s2;
        zero_state_t zst;
        logic [CNT_W-1:0] cnt;
        logic [POS_W-1:0] pos;
        logic err;
        logic loaded;
    } state_t;
endpackage : enc_ctl_pkg

// File: sim/plc_model.sv
// Behavioural controller that drives the zero/preset and direction pins
module plc_model (
    // Clock
    input wire logic clock,
    // Pins toward the encoder
    output logic zero_out,
    output logic dir_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Idle low, so no load can start by accident
    initial begin
        zero_out = 1'b0;
        dir_out = 1'b0;
    end

    // Direction settles through the synchroniser before any pulse
    task automatic set_dir(input logic d);
        @(negedge clock);
        dir_out = d;
        repeat (4) @(negedge clock);
    endtask

    // Caller keeps the shaft still for the whole pulse
    task automatic pulse(input int n);
        @(negedge clock);
        zero_out = 1'b1;
        repeat (n) @(negedge clock);
        zero_out = 1'b0;
    endtask
endmodule // plc_model

// File: sim/encoder_zero_preset_direction_bench.sv
// Self-checking bench of the encoder zero/preset and direction logic
module encoder_zero_preset_direction_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic zero_in;
    logic dir_in;
    enc_ctl_pkg::cfg_t cfg = '0;
    enc_ctl_pkg::sense_t sense = '0;
    logic [enc_ctl_pkg::POS_W-1:0] position;
    logic dir_ccw;
    logic error;
    logic load_done;
    logic [enc_ctl_pkg::POS_W-1:0] exp_pos;
    logic dir_exp;
    logic got;
    int n_mismatch = 0;
    int checks_done = 0;

    always #50 clock = ~clock;

    plc_model u_plc (.clock(clock), .zero_out(zero_in), .dir_out(dir_in));

    enc_zero_dir u_dut (.clock(clock), .rstn(rstn), .zero_in(zero_in), .dir_in(dir_in),
        .cfg(cfg), .sense(sense), .position(position), .dir_ccw(dir_ccw), .error(error),
        .load_done(load_done));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Expectations
    // ************************************************************
    // Up for a clockwise move with direction low, counter-clockwise with it high
    function automatic logic [enc_ctl_pkg::POS_W-1:0] next_pos(
        input logic [enc_ctl_pkg::POS_W-1:0] p, input logic cw, input logic ccw_up);
        return (cw != ccw_up) ? p + 39'h00_0000_0001 : p - 39'h00_0000_0001;
    endfunction

    // An uncovered backup loss keeps only the singleturn part
    function automatic logic [enc_ctl_pkg::POS_W-1:0] drop_turns(
        input logic [enc_ctl_pkg::POS_W-1:0] p);
        return {enc_ctl_pkg::MT_ZERO, p[enc_ctl_pkg::ST_W-1:0]};
    endfunction

    // ************************************************************
    // Stimulus helpers
    // ************************************************************
    task automatic power_cycle();
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
    endtask

    task automatic step(input logic cw);
        @(negedge clock);
        sense.step = 1'b1;
        sense.step_cw = cw;
        exp_pos = next_pos(exp_pos, cw, dir_exp);
        @(negedge clock);
        sense.step = 1'b0;
        @(negedge clock);
        chk("position", position, exp_pos);
    endtask

    // Bounded watch for the one-cycle load strobe
    task automatic pulse_load(input int n, input logic expect_load);
        u_plc.pulse(n);
        got = 1'b0;
        repeat (8) begin
            @(negedge clock);
            got = got | load_done;
        end
        chk("load_done", got, expect_load);
        chk("position", position, exp_pos);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h8B391D3C));
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        exp_pos = enc_ctl_pkg::POS_ZERO;
        pulse_load(1010, 1'b1);
        for (int d = 0; d < 2; d++) begin
            dir_exp = 1'(d);
            u_plc.set_dir(dir_exp);
            chk("dir_ccw", dir_ccw, dir_exp);
            repeat (6) step(1'($urandom_range(0, 1)));
        end
        // Well short of the qualifying time, so boundary jitter cannot matter
        pulse_load(900, 1'b0);
        // Corner cases either side of the qualifying time
        pulse_load(999, 1'b0);
        exp_pos = enc_ctl_pkg::POS_ZERO;
        pulse_load(1000, 1'b1);
        cfg.variant_biss = 1'b1;
        for (int e = 0; e < 4; e++) begin
            cfg.preset_hw_en = 2'(e);
            cfg.preset_val = enc_ctl_pkg::POS_W'({$urandom(), $urandom()});
            if (e == 1) exp_pos = cfg.preset_val;
            pulse_load(1010, e == 1);
        end
        step(1'b1);
        cfg.preset_hw_en = 2'h0;
        cfg.preset_val = enc_ctl_pkg::POS_W'({$urandom(), $urandom()});
        cfg.preset_cmd = 1'b1;
        @(negedge clock);
        cfg.preset_cmd = 1'b0;
        exp_pos = cfg.preset_val;
        chk("load_done", load_done, 1'b1);
        @(negedge clock);
        chk("position", position, exp_pos);
        // Power cycle with the backup intact keeps the whole position
        power_cycle();
        chk("position", position, exp_pos);
        chk("error", error, 1'b0);
        sense.batt_lost_flag = 1'b1;
        repeat (3) @(negedge clock);
        sense.batt_lost_flag = 1'b0;
        repeat (3) @(negedge clock);
        chk("error", error, 1'b1);
        power_cycle();
        exp_pos = drop_turns(exp_pos);
        chk("error", error, 1'b0);
        chk("position", position, exp_pos);
        end_sim();
    end
endmodule // encoder_zero_preset_direction_bench
